// *** design/fwc_pkg.sv ***
// Shared constants for the four-way mixed cache core
package fwc_pkg;
  localparam int WAYS = 4;
  localparam int ENTRIES = 64;
  localparam int LINE_WORDS = 4;
  localparam int TAG_W = 19;
  localparam int LRU_W = 6;
  localparam int IDX_LO = 4;
  localparam int IDX_HI = 9;
  localparam int TAG_LO = 10;
  localparam int TAG_HI = 28;
  localparam int REGION_LO = 29;
  localparam int REGION_HI = 31;
  localparam logic [2:0] REGION_CACHED = 3'h0;
  localparam logic [2:0] REGION_THRU = 3'h1;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int CTL_EN = 0;
  localparam int CTL_IFI = 1;
  localparam int CTL_DFI = 2;
  localparam int CTL_TW = 3;
  localparam int CTL_PURGE = 4;
  localparam int CTL_CB = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [LRU_W-1:0] LRU_PURGED = 6'h00;
  localparam logic [1:0] LAST_BEAT = 2'h3;
endpackage

// *** design/fwc_way_match.sv ***
// Tag comparator for one way of the cache
`timescale 1ns/10ps
module fwc_way_match
  import fwc_pkg::*;
(
  // Stored entry
  input wire logic valid,
  input wire logic [TAG_W-1:0] stored,
  // Probe
  input wire logic [TAG_W-1:0] probe,
  // Result
  output logic hit
);
  // An invalid way never matches, whatever its stored tag
  assign hit = valid && (stored == probe);
endmodule // fwc_way_match

// *** design/fwc_core.sv ***
// Four-way mixed instruction/data cache core with write-back buffer
// Functional notes
// - Index one of 64 entries, compare tag against all four ways.
// - Invalid ways never match.
// - Read hit data one cycle after compare, back-to-back without waits.
// - Read miss picks LRU victim, writes tag and valid, fetches four longwords.
// - Fill walks offsets by 4 with wrap, requested longword comes last.
// - Missed read data goes to CPU one cycle after last fill write.
// - Write-through always writes memory, updates array only on hit.
// - Write-through drives internal bus one cycle later, CPU stalls to end.
// - Copy-back write hit updates array, sets dirty, two cycles.
// - Copy-back write miss allocates with valid and dirty, merges on fill.
// - Dirty victim goes to buffer, fill first, then buffer drains.
// - Buffer holds one 16-byte line and its address.
// - Cache-through read fetches only the addressed item, no fill.
// - Cache-through write goes out like write-through, array untouched.
// - Six LRU bits per entry updated on hits and replacements.
// - Victim chosen from LRU bits by the fixed selection table.
// - Purge zeroes LRU so way 3 is replaced first.
// - Fill-inhibit bits make read misses bypass the arrays.
// - Two-way mode replaces only ways 2 and 3, compares all four.
// - Tag and valid written before the fill completes.
// - Purge clears every valid and LRU bit within one cycle.
// - Reset clears enable; tags, valid and data stay uninitialised.
// - Lines are 16 bytes, index from address bits 9 to 4.
// - Region 000 cacheable when enabled, 001 is cache-through alias.
// - Purge bit clears itself and always reads zero.
// - Copy-back select 0 means write-through, 1 means copy-back.
`timescale 1ns/10ps
module fwc_core
  import fwc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // CPU cache bus
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic cpu_ifetch,
  input wire logic [31:0] cpu_addr,
  input wire logic [1:0] cpu_size,
  input wire logic [31:0] cpu_wdata,
  output logic [31:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_busy,
  // Internal memory bus
  output logic mem_req,
  output logic mem_wr,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WDATA, ST_MISS, ST_FILL, ST_EXTWR, ST_THRU
  } fwc_state_t;

  // Arrays are not reset: valid and LRU bits are undefined until a purge, tags and data stay so after it
  logic [TAG_W-1:0] tag_q [WAYS][ENTRIES];
  logic [ENTRIES-1:0] valid_q [WAYS];
  logic [ENTRIES-1:0] dirty_q [WAYS];
  logic [LRU_W-1:0] lru_q [ENTRIES];
  logic [31:0] data_q [WAYS][ENTRIES][LINE_WORDS];
  logic [31:0] wbb_data_q [LINE_WORDS];

  fwc_state_t st_q, st_d;
  logic [7:0] ctl_q, ctl_d;
  logic purge_q, purge_d;
  logic [31:0] addr_q, addr_d;
  logic [1:0] size_q, size_d;
  logic wr_q, wr_d;
  logic ifetch_q, ifetch_d;
  logic [31:0] wdata_q, wdata_d;
  logic [1:0] way_q, way_d;
  logic [1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic mreq_q, mreq_d;
  logic mwr_q, mwr_d;
  logic [31:0] maddr_q, maddr_d;
  logic [1:0] msize_q, msize_d;
  logic [31:0] mwdata_q, mwdata_d;
  logic drn_q, drn_d;
  logic [1:0] drn_cnt_q, drn_cnt_d;
  logic wbb_full_q, wbb_full_d;
  logic [31:0] wbb_addr_q, wbb_addr_d;
  logic [31:0] reg_rdata_q, reg_rdata_d;

  // Array write controls
  logic dw_en;
  logic [1:0] dw_way;
  logic [1:0] dw_word;
  logic [31:0] dw_val;
  logic tw_en;
  logic tw_dirty;
  logic dset_en;
  logic lu_en;
  logic [1:0] lu_way;
  logic wbb_load;

  // Lookup
  logic [31:0] look_addr;
  logic [5:0] look_idx;
  logic [TAG_W-1:0] look_tag;
  logic [WAYS-1:0] way_hit;
  logic any_hit;
  logic [1:0] hit_way;
  logic [1:0] vict;
  logic [1:0] fill_word;
  logic main_ack;

  function automatic logic [LRU_W-1:0] lru_next(
    input logic [LRU_W-1:0] l, input logic [1:0] w);
    logic [LRU_W-1:0] r;
    r = l;
    unique case (w)
      2'h0: r[5:3] = 3'h0;
      2'h1: begin
        r[5] = 1'b1;
        r[2:1] = 2'h0;
      end
      2'h2: begin
        r[4] = 1'b1;
        r[2] = 1'b1;
        r[0] = 1'b0;
      end
      2'h3: begin
        r[3] = 1'b1;
        r[1:0] = 2'h3;
      end
    endcase
    return r;
  endfunction

  function automatic logic [1:0] pick_victim(
    input logic [LRU_W-1:0] l, input logic tw);
    if (tw)
      return l[0] ? 2'h2 : 2'h3;
    else if (l[5] && l[4] && l[3])
      return 2'h0;
    else if (!l[5] && l[2] && l[1])
      return 2'h1;
    else if (!l[4] && !l[2] && l[0])
      return 2'h2;
    else
      return 2'h3;
  endfunction

  // Lanes are big-endian: byte offset 0 sits in bits 31:24
  function automatic logic [3:0] lane_mask(
    input logic [1:0] off, input logic [1:0] sz);
    if (sz == SZ_LONG)
      return 4'hf;
    else if (sz == SZ_WORD)
      return off[1] ? 4'h3 : 4'hc;
    else
      return 4'h8 >> off;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old, input logic [31:0] nw, input logic [3:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (m[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  assign look_addr = (st_q == ST_IDLE) ? cpu_addr : addr_q;
  assign look_idx = look_addr[IDX_HI:IDX_LO];
  assign look_tag = look_addr[TAG_HI:TAG_LO];

  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++) begin : g_way
      fwc_way_match u_match (
        .valid(valid_q[gw][look_idx]),
        .stored(tag_q[gw][look_idx]),
        .probe(look_tag),
        .hit(way_hit[gw])
      );
    end
  endgenerate

  assign any_hit = |way_hit;
  assign hit_way = way_hit[3] ? 2'h3 : way_hit[2] ? 2'h2 :
                   way_hit[1] ? 2'h1 : 2'h0;
  assign vict = pick_victim(lru_q[look_idx], ctl_q[CTL_TW]);
  assign fill_word = addr_q[3:2] + 2'h1 + cnt_q;
  assign main_ack = mreq_q && mem_ack && !drn_q;

  always_comb begin
    logic cached;
    logic cback;
    cached = 1'b0;
    cback = 1'b0;
    st_d = st_q;
    ctl_d = ctl_q;
    purge_d = 1'b0;
    addr_d = addr_q;
    size_d = size_q;
    wr_d = wr_q;
    ifetch_d = ifetch_q;
    wdata_d = wdata_q;
    way_d = way_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    mreq_d = mreq_q;
    mwr_d = mwr_q;
    maddr_d = maddr_q;
    msize_d = msize_q;
    mwdata_d = mwdata_q;
    drn_d = drn_q;
    drn_cnt_d = drn_cnt_q;
    wbb_full_d = wbb_full_q;
    wbb_addr_d = wbb_addr_q;
    reg_rdata_d = 32'h0;
    dw_en = 1'b0;
    dw_way = way_q;
    dw_word = addr_q[3:2];
    dw_val = 32'h0;
    tw_en = 1'b0;
    tw_dirty = 1'b0;
    dset_en = 1'b0;
    lu_en = 1'b0;
    lu_way = way_q;
    wbb_load = 1'b0;

    if (reg_wr && reg_addr == REG_CTRL) begin
      ctl_d = reg_wdata[7:0];
      ctl_d[CTL_PURGE] = 1'b0;
      purge_d = reg_wdata[CTL_PURGE];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata_d = {24'h0, ctl_q};
        REG_STAT: reg_rdata_d = {30'h0, wbb_full_q, busy_q};
        default: reg_rdata_d = 32'h0;
      endcase
    end

    // Buffer drain word finished
    if (mreq_q && mem_ack && drn_q) begin
      mreq_d = 1'b0;
      drn_d = 1'b0;
      drn_cnt_d = drn_cnt_q + 2'h1;
      if (drn_cnt_q == LAST_BEAT)
        wbb_full_d = 1'b0;
    end

    cached = look_addr[REGION_HI:REGION_LO] == REGION_CACHED
             && ctl_q[CTL_EN];
    cback = ctl_q[CTL_CB];

    unique case (st_q)
      ST_IDLE: begin
        if (cpu_req) begin
          addr_d = cpu_addr;
          size_d = cpu_size;
          wr_d = cpu_wr;
          ifetch_d = cpu_ifetch;
          way_d = hit_way;
          if (cpu_wr) begin
            st_d = ST_WDATA;
            busy_d = 1'b1;
            // A drain word may still own the bus; its address must hold
            if (!mreq_q)
              maddr_d = cpu_addr;
          end else if (cached && any_hit) begin
            rdata_d = data_q[hit_way][look_idx][cpu_addr[3:2]];
            rvalid_d = 1'b1;
            lu_en = 1'b1;
            lu_way = hit_way;
          end else if (cached && !(cpu_ifetch ? ctl_q[CTL_IFI]
                                               : ctl_q[CTL_DFI])) begin
            st_d = ST_MISS;
            busy_d = 1'b1;
          end else begin
            st_d = ST_THRU;
            busy_d = 1'b1;
          end
        end else if (wbb_full_q && !mreq_q) begin
          // Drain only between CPU requests; steady hits delay it
          mreq_d = 1'b1;
          drn_d = 1'b1;
          mwr_d = 1'b1;
          msize_d = SZ_LONG;
          maddr_d = {wbb_addr_q[31:4], drn_cnt_q, 2'h0};
          mwdata_d = wbb_data_q[drn_cnt_q];
        end
      end
      ST_WDATA: begin
        wdata_d = cpu_wdata;
        if (cached && cback && any_hit) begin
          dw_en = 1'b1;
          dw_way = hit_way;
          dw_val = merge(data_q[hit_way][look_idx][addr_q[3:2]], cpu_wdata,
                         lane_mask(addr_q[1:0], size_q));
          dset_en = 1'b1;
          lu_en = 1'b1;
          lu_way = hit_way;
          busy_d = 1'b0;
          st_d = ST_IDLE;
        end else if (cached && cback) begin
          st_d = ST_MISS;
        end else begin
          if (cached && any_hit) begin
            dw_en = 1'b1;
            dw_way = hit_way;
            dw_val = merge(data_q[hit_way][look_idx][addr_q[3:2]],
                           cpu_wdata, lane_mask(addr_q[1:0], size_q));
            lu_en = 1'b1;
            lu_way = hit_way;
          end
          // Cache-through writes compare tags but never touch the array
          st_d = ST_EXTWR;
          if (!mreq_q) begin
            mreq_d = 1'b1;
            mwr_d = 1'b1;
            maddr_d = addr_q;
            msize_d = size_q;
            mwdata_d = cpu_wdata;
          end
        end
      end
      ST_MISS: begin
        if (!(valid_q[vict][look_idx] && dirty_q[vict][look_idx]
              && wbb_full_q)) begin
          way_d = vict;
          tw_en = 1'b1;
          tw_dirty = wr_q;
          lu_en = 1'b1;
          lu_way = vict;
          cnt_d = 2'h0;
          st_d = ST_FILL;
          if (valid_q[vict][look_idx] && dirty_q[vict][look_idx]) begin
            wbb_load = 1'b1;
            wbb_full_d = 1'b1;
            drn_cnt_d = 2'h0;
            wbb_addr_d = {REGION_CACHED, tag_q[vict][look_idx], look_idx,
                          4'h0};
          end
        end else if (!mreq_q) begin
          // Drain only runs when idle, so a stalled miss drains it itself
          mreq_d = 1'b1;
          drn_d = 1'b1;
          mwr_d = 1'b1;
          msize_d = SZ_LONG;
          maddr_d = {wbb_addr_q[31:4], drn_cnt_q, 2'h0};
          mwdata_d = wbb_data_q[drn_cnt_q];
        end
      end
      ST_FILL: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwr_d = 1'b0;
          msize_d = SZ_LONG;
          maddr_d = {addr_q[31:4], fill_word, 2'h0};
        end else if (main_ack) begin
          dw_en = 1'b1;
          dw_word = fill_word;
          dw_val = mem_rdata;
          if (wr_q && fill_word == addr_q[3:2])
            dw_val = merge(mem_rdata, wdata_q,
                           lane_mask(addr_q[1:0], size_q));
          if (cnt_q == LAST_BEAT) begin
            mreq_d = 1'b0;
            busy_d = 1'b0;
            st_d = ST_IDLE;
            rdata_d = mem_rdata;
            rvalid_d = !wr_q;
          end else begin
            cnt_d = cnt_q + 2'h1;
            maddr_d = {addr_q[31:4], fill_word + 2'h1, 2'h0};
          end
        end
      end
      ST_EXTWR: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwr_d = 1'b1;
          maddr_d = addr_q;
          msize_d = size_q;
          mwdata_d = wdata_q;
        end else if (main_ack) begin
          mreq_d = 1'b0;
          busy_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      ST_THRU: begin
        if (!mreq_q) begin
          mreq_d = 1'b1;
          mwr_d = 1'b0;
          maddr_d = addr_q;
          msize_d = size_q;
        end else if (main_ack) begin
          mreq_d = 1'b0;
          busy_d = 1'b0;
          rdata_d = mem_rdata;
          rvalid_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      ctl_q <= CTL_RESET;
      purge_q <= 1'b0;
      addr_q <= 32'h0;
      size_q <= SZ_BYTE;
      wr_q <= 1'b0;
      ifetch_q <= 1'b0;
      wdata_q <= 32'h0;
      way_q <= 2'h0;
      cnt_q <= 2'h0;
      busy_q <= 1'b0;
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
      mreq_q <= 1'b0;
      mwr_q <= 1'b0;
      maddr_q <= 32'h0;
      msize_q <= SZ_BYTE;
      mwdata_q <= 32'h0;
      drn_q <= 1'b0;
      drn_cnt_q <= 2'h0;
      wbb_full_q <= 1'b0;
      wbb_addr_q <= 32'h0;
      reg_rdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      purge_q <= purge_d;
      addr_q <= addr_d;
      size_q <= size_d;
      wr_q <= wr_d;
      ifetch_q <= ifetch_d;
      wdata_q <= wdata_d;
      way_q <= way_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      mreq_q <= mreq_d;
      mwr_q <= mwr_d;
      maddr_q <= maddr_d;
      msize_q <= msize_d;
      mwdata_q <= mwdata_d;
      drn_q <= drn_d;
      drn_cnt_q <= drn_cnt_d;
      wbb_full_q <= wbb_full_d;
      wbb_addr_q <= wbb_addr_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Array ports; reset leaves contents alone so a purge is still required
  always_ff @(posedge ref_clk) begin
    if (dw_en)
      data_q[dw_way][look_idx][dw_word] <= dw_val;
    if (wbb_load) begin
      for (int i = 0; i < LINE_WORDS; i++)
        wbb_data_q[i] <= data_q[vict][look_idx][i];
    end
    if (tw_en) begin
      tag_q[vict][look_idx] <= look_tag;
      dirty_q[vict][look_idx] <= tw_dirty;
    end
    if (dset_en)
      dirty_q[dw_way][look_idx] <= 1'b1;
    if (purge_q) begin
      for (int e = 0; e < ENTRIES; e++)
        lru_q[e] <= LRU_PURGED;
      for (int w = 0; w < WAYS; w++)
        valid_q[w] <= '0;
    end else begin
      if (lu_en)
        lru_q[look_idx] <= lru_next(lru_q[look_idx], lu_way);
      if (tw_en)
        valid_q[vict][look_idx] <= 1'b1;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
  assign cpu_busy = busy_q;
  assign mem_req = mreq_q;
  assign mem_wr = mwr_q;
  assign mem_addr = maddr_q;
  assign mem_size = msize_q;
  assign mem_wdata = mwdata_q;
endmodule // fwc_core

// *** bench/fwc_mem_model.sv ***
// Internal memory bus partner with variable answer latency
`timescale 1ns/10ps
module fwc_mem_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus from the cache
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  // Extra wait cycles before each answer
  input wire logic [1:0] slow
);
  logic [31:0] st [logic [31:0]];
  logic [31:0] log_q [$];
  logic [31:0] k;
  logic [1:0] cnt;
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5a5a, a[15:0]};
  endfunction
  initial begin
    mem_rdata = 32'h0;
    mem_ack = 1'b0;
    cnt = 2'h0;
  end
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    // Released data lines keep changing so stale values never pass
    mem_rdata <= ~mem_rdata;
    // Cached and uncached regions alias the same storage
    k = {3'h0, mem_addr[28:0]};
    if (sys_rst) begin
      cnt <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      cnt <= cnt + 2'h1;
      if (cnt >= slow) begin
        cnt <= 2'h0;
        mem_ack <= 1'b1;
        log_q.push_back({mem_wr, mem_addr[30:0]});
        if (mem_wr) begin
          st[k] = mem_wdata;
        end else begin
          mem_rdata <= st.exists(k) ? st[k] : pat(k);
        end
      end
    end
  end
endmodule // fwc_mem_model

// *** bench/fwc_core_checker.sv ***
// Port assertions for the cache core
`timescale 1ns/10ps
module fwc_core_checker
  import fwc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // CPU cache bus
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_rvalid,
  input wire logic cpu_busy,
  // Internal memory bus
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  purge_reads_zero_a: assert property (
    reg_rd && reg_addr == REG_CTRL |=> reg_rdata[CTL_PURGE] == 1'b0)
    else $error("purge bit read back as one");
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !cpu_busy && !mem_req && !cpu_rvalid)
    else $error("outputs active after reset");
  hit_pipe_a: assert property (
    cpu_req && !cpu_busy && !cpu_wr |=> cpu_rvalid || cpu_busy)
    else $error("read neither answered nor stalled");
  miss_done_a: assert property (
    cpu_rvalid |-> !cpu_busy)
    else $error("read data while still stalled");
  write_stall_a: assert property (
    cpu_req && !cpu_busy && cpu_wr |=> cpu_busy)
    else $error("write did not stall the cpu");
  thru_write_a: assert property (
    cpu_req && !cpu_busy && cpu_wr && !mem_req &&
    cpu_addr[REGION_HI:REGION_LO] == REGION_THRU ##1 1'b1 |=>
    mem_req && mem_wr && mem_addr == $past(cpu_addr, 2) &&
    mem_wdata == $past(cpu_wdata))
    else $error("through write not forwarded one cycle late");
  bus_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
    $stable(mem_wr) && $stable(mem_wdata))
    else $error("bus request changed before answer");
  fill_wrap_a: assert property (
    mem_req && !mem_wr && mem_ack ##1 mem_req && !mem_wr |->
    mem_addr[3:2] == $past(mem_addr[3:2]) + 2'h1 &&
    mem_addr[31:4] == $past(mem_addr[31:4]))
    else $error("fill words not in wrapped order");
endmodule // fwc_core_checker
bind fwc_core fwc_core_checker i_fwc_core_checker (.*);

// *** bench/tb.sv ***
// Self-checking bench for the cache core
`timescale 1ns/10ps
module tb;
  import fwc_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, cpu_req, cpu_wr, cpu_ifetch;
  logic cpu_rvalid, cpu_busy, mem_req, mem_wr, mem_ack;
  logic [1:0] reg_addr, cpu_size, slow;
  logic [31:0] reg_wdata, reg_rdata, cpu_addr, cpu_wdata, cpu_rdata;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rd;
  int error_cnt = 0;
  int n_checks = 0;
  int n0;
  fwc_core i_fwc_core (.mem_size(), .*);
  fwc_mem_model i_fwc_mem_model (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Longword address in entry 0x23 for a tag and a word
  function automatic logic [31:0] wa(input int t, input int w, input int x);
    return {1'(x), 17'h0, 4'(t), 6'h23, 2'(w), 2'h0};
  endfunction
  function automatic logic [31:0] mv(input logic [31:0] a);
    logic [31:0] k;
    k = {3'h0, a[28:0]};
    return i_fwc_mem_model.st.exists(k) ? i_fwc_mem_model.st[k] :
      i_fwc_mem_model.pat(k);
  endfunction
  function automatic int nlog();
    return i_fwc_mem_model.log_q.size();
  endfunction
  function automatic logic [31:0] lg(input int i);
    return i_fwc_mem_model.log_q[i];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Write data follows one cycle after the request
  task automatic cpu(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_wr <= w;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    cpu_wdata <= d;
    q = 32'h0;
    repeat (200) begin
      #1;
      if (w ? cpu_busy === 1'b0 : cpu_rvalid === 1'b1) break;
      @(posedge ref_clk);
    end
    q = cpu_rdata;
  endtask
  task automatic rdx(input logic [31:0] a, input int g);
    int n;
    n = nlog();
    cpu(1'b0, a, 32'h0, rd);
    chk(rd, mv({a[31:2], 2'h0}));
    chk(32'(nlog() - n), 32'(g));
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, cpu_req, cpu_wr, cpu_ifetch} = 5'h0;
    {reg_addr, slow} = 4'h0;
    {reg_wdata, cpu_addr, cpu_wdata} = 96'h0;
    cpu_size = SZ_LONG;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rreg(REG_CTRL, 32'h0);
    wreg(REG_CTRL, 32'h10);
    rreg(REG_CTRL, 32'h0);
    rreg(2'h3, 32'h0);
    wreg(REG_CTRL, 32'h01);
    slow <= 2'h2;
    n0 = nlog();
    rdx(wa(4, 2, 0), 4);
    for (int k = 0; k < 4; k++) chk(lg(n0 + k), wa(4, 3 + k, 0));
    slow <= 2'h0;
    n0 = nlog();
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      cpu_req <= (k < 4);
      cpu_addr <= wa(4, k, 0);
      #1;
      if (k > 0) chk(32'(cpu_rvalid), 32'h1);
      if (k > 0) chk(cpu_rdata, mv(wa(4, k - 1, 0)));
    end
    chk(32'(nlog() - n0), 32'h0);
    cpu(1'b1, wa(4, 1, 0), 32'hcafe_0001, rd);
    chk(lg(nlog() - 1), wa(4, 1, 1));
    rdx(wa(4, 1, 0), 0);
    cpu(1'b1, wa(5, 2, 0), 32'hcafe_0002, rd);
    rdx(wa(5, 2, 0), 4);
    rdx(wa(6, 2, 0), 4);
    rdx(wa(7, 2, 0), 4);
    rdx(wa(4, 2, 0), 0);
    rdx(wa(8, 2, 0), 4);
    rdx(wa(4, 2, 0), 0);
    rdx(wa(5, 2, 0), 4);
    rdx(wa(4, 3, 0) | 32'h2000_0000, 1);
    chk(lg(nlog() - 1), wa(4, 3, 0) | 32'h2000_0000);
    cpu(1'b1, wa(4, 0, 0) | 32'h2000_0000, 32'hbad0_0000, rd);
    cpu(1'b0, wa(4, 0, 0), 32'h0, rd);
    chk(rd, i_fwc_mem_model.pat(wa(4, 0, 0)));
    wreg(REG_CTRL, 32'h05);
    rdx(wa(9, 2, 0), 1);
    rdx(wa(9, 2, 0), 1);
    wreg(REG_CTRL, 32'h03);
    cpu_ifetch <= 1'b1;
    rdx(wa(9, 2, 0), 1);
    rdx(wa(9, 2, 0), 1);
    cpu_ifetch <= 1'b0;
    wreg(REG_CTRL, 32'h21);
    rreg(REG_CTRL, 32'h21);
    n0 = nlog();
    cpu(1'b1, wa(4, 1, 0), 32'hd00d_0003, rd);
    chk(32'(nlog() - n0), 32'h0);
    rdx(wa(7, 2, 0), 0);
    rdx(wa(5, 2, 0), 0);
    rdx(wa(8, 2, 0), 0);
    slow <= 2'h3;
    rdx(wa(10, 2, 0), 4);
    n0 = nlog();
    for (int k = 0; k < 200 && nlog() < n0 + 4; k++) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      chk(lg(n0 + k), wa(4, k, 1));
      chk(mv(wa(4, k, 0)), k == 1 ? 32'hd00d_0003 :
        i_fwc_mem_model.pat(wa(4, k, 0)));
    end
    results();
  end
endmodule // tb
